// [stepper_pkg.sv]
// Shared types, register map and constants for the stepper translator
package stepper_pkg;

  // Register byte offsets
  localparam logic [7:0]  CONFIG_OFF       = 8'h00;
  localparam logic [7:0]  STATUS_OFF       = 8'h04;

  // Config fields and reset values
  localparam int          CFG_SYNC_MASTER  = 0;
  localparam logic        SYNC_MASTER_RST  = 1'b1;

  // Status fields
  localparam int          STAT_STATE_LSB   = 0;
  localparam int          STAT_HOME_BIT    = 3;
  localparam int          STAT_LATCH_LSB   = 4;
  localparam int          STAT_DRIVE_LSB   = 8;

  // AXI responses
  localparam logic [1:0]  RESP_OKAY        = 2'h0;
  localparam logic [1:0]  RESP_SLVERR      = 2'h2;

  // Translator
  localparam logic [2:0]  HOME_STATE       = 3'h0;
  localparam logic [2:0]  STRIDE_HALF      = 3'h1;
  localparam logic [2:0]  STRIDE_FULL      = 3'h2;

  // Chopper timing on the link clock
  localparam int          LINK_PERIOD_NS   = 30;
  localparam int          CHOP_PERIOD_NS   = 30000;
  localparam int          CHOP_CYCLES      = CHOP_PERIOD_NS / LINK_PERIOD_NS;
  localparam logic [9:0]  CHOP_LAST        = 10'(CHOP_CYCLES - 1);
  localparam logic [2:0]  SYNC_HIGH_LAST   = 3'h3;

  typedef struct packed {
    logic step_n;
    logic rotation_direction;
    logic half_full;
    logic chop_target;
    logic chip_enable;
    logic translator_reset_n;
  } host_in_t;

  // Step input idles high so reset does not fake an edge
  localparam host_in_t    HOST_IN_RST      = 6'h21;

  typedef struct packed {
    logic phase_a;
    logic phase_b;
    logic phase_c;
    logic phase_d;
    logic pair_ab_inhibit_n;
    logic pair_cd_inhibit_n;
  } drive_t;

  typedef enum logic [0:0] {
    W_IDLE = 1'b0,
    W_RESP = 1'b1
  } wr_state_t;

  // Half-step table, index 0 is home; inhibit low when pair idle
  function automatic drive_t decode(input logic [2:0] s);
    logic [3:0] p;
    p = 4'h5;
    case (s)
      3'h0: p = 4'h5;
      3'h1: p = 4'h1;
      3'h2: p = 4'h9;
      3'h3: p = 4'h8;
      3'h4: p = 4'hA;
      3'h5: p = 4'h2;
      3'h6: p = 4'h6;
      3'h7: p = 4'h4;
      default: p = 4'h5;
    endcase
    return {p, p[3] | p[2], p[1] | p[0]};
  endfunction

endpackage

// [stepper_translator_chopper.sv]
// Stepper translator with dual chopper, AXI4-Lite status and config
//
// Overview of operation
// - Home flag active at state 1 (ABCD 0101); open-collector released then.
// - Two active-low inhibits: one for phases A/B, one for C/D.
// - Chop target low gates inhibits; high gates the phase lines.
// - Enable low forces both inhibits and all four phases low.
// - Direction input synchronised, so it may change at any time.
// - Host pulses step clock low; translator advances on rising edge.
// - Half/full select high runs half step, low runs full step.
// - Full step chosen at even-numbered state gives wave drive.
// - Full step chosen at odd state gives two-phase drive; home is 1.
// - Reset pulse low returns translator to state 1, ABCD 0101.
// - Anticlockwise steps the same sequences in reverse order.
// - Two-phase drive keeps both inhibits high throughout; here chop target low still lets the latches pull them low.
// - Oscillator pulse sets both latches; sense comparator clears its own.
// - Phase chopping raises the idle line of a pair, not dropping active.
//
// The placing of the registers and the AXI4-Lite slave port were chosen for this implementation.
`timescale 1ns/1ns

module stepper_translator_chopper
  import stepper_pkg::*;
(
  input  wire  logic        aclk,
  input  wire  logic        aresetn,
  input  wire  logic        ce,
  input  wire  logic        chop_clk,
  input  wire  logic [7:0]  s_axi_awaddr,
  input  wire  logic        s_axi_awvalid,
  output logic              s_axi_awready,
  input  wire  logic [31:0] s_axi_wdata,
  input  wire  logic [3:0]  s_axi_wstrb,
  input  wire  logic        s_axi_wvalid,
  output logic              s_axi_wready,
  output logic [1:0]        s_axi_bresp,
  output logic              s_axi_bvalid,
  input  wire  logic        s_axi_bready,
  input  wire  logic [7:0]  s_axi_araddr,
  input  wire  logic        s_axi_arvalid,
  output logic              s_axi_arready,
  output logic [31:0]       s_axi_rdata,
  output logic [1:0]        s_axi_rresp,
  output logic              s_axi_rvalid,
  input  wire  logic        s_axi_rready,
  input  wire  host_in_t    host_in,
  input  wire  logic        ab_current_sense,
  input  wire  logic        cd_current_sense,
  input  wire  logic        sync_in,
  output logic              sync_out,
  output logic              sync_oe,
  output drive_t            bridge,
  output logic              home_sink_on
);

  //////////////////////////////////////////////////////////////////////////
  // Bus-clock state

  typedef struct packed {
    host_in_t    in_s1;
    host_in_t    in_s2;
    logic        step_prev;
    logic [2:0]  state;
    logic [1:0]  lat_s1;
    logic [1:0]  lat_s2;
    drive_t      bridge;
    logic        home_sink_on;
    logic        sync_master;
    logic        aw_got;
    logic [7:0]  aw_addr;
    logic        w_got;
    logic [31:0] w_data;
    logic        w_strb0;
    wr_state_t   wr;
    logic        awready;
    logic        wready;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        arready;
    logic        rvalid;
    logic [31:0] rdata;
    logic [1:0]  rresp;
  } core_t;

  typedef struct packed {
    logic        master_s1;
    logic        master_s2;
    logic        sync_s1;
    logic        sync_s2;
    logic        sync_prev;
    logic [1:0]  sense_s1;
    logic [1:0]  sense_s2;
    logic [9:0]  div;
    logic [2:0]  high_cnt;
    logic        sync_out;
    logic        sync_oe;
    logic [1:0]  latch;
  } chop_t;

  core_t       st;
  core_t       next_st;
  chop_t       c;
  chop_t       next_c;
  logic        step_edge;
  logic        rst_meta;
  logic        chop_rst_n;
  logic        pulse_int;
  logic        osc_pulse;

  assign step_edge = st.in_s2.step_n & ~st.step_prev;

  always_comb begin
    drive_t     pat;
    logic [2:0] stride;
    logic [31:0] status;
    next_st = st;
    pat     = '0;
    stride  = STRIDE_HALF;
    status  = '0;
    if (ce) begin
      next_st.in_s1     = host_in;
      next_st.in_s2     = st.in_s1;
      next_st.step_prev = st.in_s2.step_n;
      next_st.lat_s1    = c.latch;
      next_st.lat_s2    = st.lat_s1;

      stride = st.in_s2.half_full ? STRIDE_HALF : STRIDE_FULL;
      if (!st.in_s2.translator_reset_n) begin
        next_st.state = HOME_STATE;
      end else if (step_edge) begin
        if (st.in_s2.rotation_direction) begin
          next_st.state = st.state + stride;
        end else begin
          next_st.state = st.state - stride;
        end
      end

      pat = decode(next_st.state);
      if (!st.in_s2.chop_target) begin
        pat.pair_ab_inhibit_n = pat.pair_ab_inhibit_n & st.lat_s2[0];
        pat.pair_cd_inhibit_n = pat.pair_cd_inhibit_n & st.lat_s2[1];
      end else begin
        if (!st.lat_s2[0] && (pat.phase_a || pat.phase_b)) begin
          pat.phase_a = 1'b1;
          pat.phase_b = 1'b1;
        end
        if (!st.lat_s2[1] && (pat.phase_c || pat.phase_d)) begin
          pat.phase_c = 1'b1;
          pat.phase_d = 1'b1;
        end
      end
      next_st.bridge = st.in_s2.chip_enable ? pat : '0;
      next_st.home_sink_on = (next_st.state != HOME_STATE);

      // Write channel: address and data in any order
      if (s_axi_awvalid && st.awready) begin
        next_st.aw_got  = 1'b1;
        next_st.aw_addr = s_axi_awaddr;
      end
      if (s_axi_wvalid && st.wready) begin
        next_st.w_got   = 1'b1;
        next_st.w_data  = s_axi_wdata;
        next_st.w_strb0 = s_axi_wstrb[0];
      end
      case (st.wr)
        W_IDLE: begin
          if (st.aw_got && st.w_got) begin
            next_st.aw_got = 1'b0;
            next_st.w_got  = 1'b0;
            next_st.bvalid = 1'b1;
            next_st.wr     = W_RESP;
            next_st.bresp  = RESP_SLVERR;
            if (st.aw_addr == CONFIG_OFF) begin
              next_st.bresp = RESP_OKAY;
              if (st.w_strb0) begin
                next_st.sync_master = st.w_data[CFG_SYNC_MASTER];
              end
            end else if (st.aw_addr == STATUS_OFF) begin
              // Read-only; write dropped but accepted
              next_st.bresp = RESP_OKAY;
            end
          end
        end
        W_RESP: begin
          if (s_axi_bready) begin
            next_st.bvalid = 1'b0;
            next_st.wr     = W_IDLE;
          end
        end
        default: next_st.wr = W_IDLE;
      endcase
      next_st.awready = ~next_st.aw_got & (next_st.wr == W_IDLE);
      next_st.wready  = ~next_st.w_got & (next_st.wr == W_IDLE);

      // Read channel
      status[STAT_STATE_LSB +: 3]  = st.state;
      status[STAT_HOME_BIT]        = (st.state == HOME_STATE);
      status[STAT_LATCH_LSB +: 2]  = st.lat_s2;
      status[STAT_DRIVE_LSB +: 6]  = st.bridge;
      if (s_axi_arvalid && st.arready) begin
        next_st.rvalid = 1'b1;
        next_st.rresp  = RESP_OKAY;
        next_st.rdata  = '0;
        if (s_axi_araddr == CONFIG_OFF) begin
          next_st.rdata[CFG_SYNC_MASTER] = st.sync_master;
        end else if (s_axi_araddr == STATUS_OFF) begin
          next_st.rdata = status;
        end else begin
          next_st.rresp = RESP_SLVERR;
        end
      end else if (st.rvalid && s_axi_rready) begin
        next_st.rvalid = 1'b0;
      end
      next_st.arready = ~next_st.rvalid;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st             <= '0;
      st.in_s1       <= HOST_IN_RST;
      st.in_s2       <= HOST_IN_RST;
      st.step_prev   <= 1'b1;
      st.sync_master <= SYNC_MASTER_RST;
      st.wr          <= W_IDLE;
      st.awready     <= 1'b1;
      st.wready      <= 1'b1;
      st.arready     <= 1'b1;
    end else begin
      st <= next_st;
    end
  end

  assign s_axi_awready = st.awready;
  assign s_axi_wready  = st.wready;
  assign s_axi_bvalid  = st.bvalid;
  assign s_axi_bresp   = st.bresp;
  assign s_axi_arready = st.arready;
  assign s_axi_rvalid  = st.rvalid;
  assign s_axi_rdata   = st.rdata;
  assign s_axi_rresp   = st.rresp;
  assign bridge        = st.bridge;
  assign home_sink_on  = st.home_sink_on;

  //////////////////////////////////////////////////////////////////////////
  // Chopper on the link clock

  // Reset release synchronised into the link domain
  always_ff @(posedge chop_clk) begin
    rst_meta   <= aresetn;
    chop_rst_n <= rst_meta;
  end

  assign pulse_int = (c.div == CHOP_LAST);
  assign osc_pulse = c.master_s2 ? pulse_int : (c.sync_s2 & ~c.sync_prev);

  always_comb begin
    next_c           = c;
    next_c.master_s1 = st.sync_master;
    next_c.master_s2 = c.master_s1;
    next_c.sync_s1   = sync_in;
    next_c.sync_s2   = c.sync_s1;
    next_c.sync_prev = c.sync_s2;
    next_c.sense_s1  = {cd_current_sense, ab_current_sense};
    next_c.sense_s2  = c.sense_s1;
    next_c.div       = pulse_int ? '0 : c.div + 10'h001;
    next_c.sync_oe   = c.master_s2;
    if (pulse_int) begin
      next_c.high_cnt = '0;
      next_c.sync_out = 1'b1;
    end else if (c.sync_out) begin
      next_c.high_cnt = c.high_cnt + 3'h1;
      next_c.sync_out = (c.high_cnt != SYNC_HIGH_LAST);
    end
    for (int i = 0; i < 2; i++) begin
      if (osc_pulse) begin
        next_c.latch[i] = 1'b1;
      end else if (c.sense_s2[i]) begin
        next_c.latch[i] = 1'b0;
      end
    end
  end

  always_ff @(posedge chop_clk) begin
    if (!chop_rst_n) begin
      c           <= '0;
      c.master_s1 <= SYNC_MASTER_RST;
      c.master_s2 <= SYNC_MASTER_RST;
    end else begin
      c <= next_c;
    end
  end

  assign sync_out = c.sync_out;
  assign sync_oe  = c.sync_oe;

  //////////////////////////////////////////////////////////////////////////
  // Checks

  a_home_flag: assert property (
    @(posedge aclk) disable iff (!aresetn)
    ce && !st.in_s2.translator_reset_n |=> !home_sink_on [*2])
    else $error("home sink not released after reset");

  a_enable_off: assert property (
    @(posedge aclk) disable iff (!aresetn)
    ce && !st.in_s2.chip_enable |=> bridge == '0)
    else $error("outputs not forced low with enable low");

  a_step_half_cw: assert property (
    @(posedge aclk) disable iff (!aresetn)
    ce && step_edge && st.in_s2.translator_reset_n && st.in_s2.half_full
    && st.in_s2.rotation_direction |=> st.state == $past(st.state) + 3'h1)
    else $error("half step clockwise did not add one");

  a_step_full_ccw: assert property (
    @(posedge aclk) disable iff (!aresetn)
    ce && step_edge && st.in_s2.translator_reset_n && !st.in_s2.half_full
    && !st.in_s2.rotation_direction |=> st.state == $past(st.state) - 3'h2)
    else $error("full step anticlockwise did not subtract two");

  a_no_step_hold: assert property (
    @(posedge aclk) disable iff (!aresetn)
    ce && !step_edge && st.in_s2.translator_reset_n |=> $stable(st.state))
    else $error("translator moved without a step edge");

  a_reset_home: assert property (
    @(posedge aclk) disable iff (!aresetn)
    ce && !st.in_s2.translator_reset_n && st.in_s2.chip_enable
    && (!st.in_s2.chop_target || st.lat_s2 == 2'h3)
    |=> st.state == HOME_STATE && bridge[5:2] == 4'h5)
    else $error("reset did not restore home pattern");

  a_two_phase_inh: assert property (
    @(posedge aclk) disable iff (!aresetn)
    ce && !step_edge && st.in_s2.translator_reset_n && !st.state[0]
    && st.in_s2.chip_enable && st.in_s2.chop_target
    |=> bridge.pair_ab_inhibit_n && bridge.pair_cd_inhibit_n)
    else $error("inhibit low in two-phase drive");

  a_chop_phase: assert property (
    @(posedge aclk) disable iff (!aresetn)
    ce && st.in_s2.chip_enable && st.in_s2.chop_target && !st.lat_s2[0]
    && !step_edge && st.in_s2.translator_reset_n
    && (decode(st.state).phase_a || decode(st.state).phase_b)
    |=> bridge.phase_a && bridge.phase_b)
    else $error("idle phase line not raised while chopping");

  a_latch_set: assert property (
    @(posedge chop_clk) disable iff (!chop_rst_n)
    osc_pulse |=> c.latch == 2'h3 ##1 (c.latch[0] || $past(c.sense_s2[0])))
    else $error("oscillator pulse did not set latches");

  a_sync_drive: assert property (
    @(posedge chop_clk) disable iff (!chop_rst_n)
    c.master_s2 && pulse_int |=> sync_out [*4] ##1 !sync_out)
    else $error("sync pin pulse width wrong");

endmodule

// [winding_model.sv]
// Far-side winding and sense comparator model for the chopper
`timescale 1ns/1ns

module winding_model (
  input  wire logic       chop_clk,
  input  wire logic       sync_pin,
  input  wire logic [9:0] ab_dly,
  input  wire logic [9:0] cd_dly,
  output logic            ab_sense,
  output logic            cd_sense
);
  logic [9:0] cnt;
  logic       last;
  logic       pulse;

  assign pulse = sync_pin && !last;

  initial begin
    cnt      = 10'h3FF;
    last     = 1'h0;
    ab_sense = 1'h0;
    cd_sense = 1'h0;
  end

  ////////////////////////////////////////////////////////////////////////
  // Current rebuilds after each chopper pulse; delay 0 never peaks
  // Comparator trips briefly at peak, since cut drive lets current decay
  always @(posedge chop_clk) begin
    last     <= sync_pin;
    cnt      <= pulse ? 10'h000 : (cnt == 10'h3FF ? cnt : cnt + 10'h001);
    ab_sense <= !pulse && ab_dly != 10'h000 && cnt >= ab_dly
                && cnt - ab_dly < 10'h004;
    cd_sense <= !pulse && cd_dly != 10'h000 && cnt >= cd_dly
                && cnt - cd_dly < 10'h004;
  end
endmodule

// [tb.sv]
// Testbench for the stepper translator with chopper
`timescale 1ns/1ns

module tb
  import stepper_pkg::*;
;
  logic        aclk, aresetn, ce, chop_clk, ext_on, ext_lvl, sync_pin;
  logic [7:0]  awaddr, araddr;
  logic [31:0] wdata, rdata, rd;
  logic        awvalid, wvalid, bready, arvalid, rready;
  logic        awready, wready, bvalid, arready, rvalid;
  logic [1:0]  bresp, rresp, rsp;
  logic        ab_sense, cd_sense, sync_out, sync_oe, home_sink_on;
  logic [9:0]  ab_dly, cd_dly;
  host_in_t    host;
  drive_t      bridge;
  int          fails = 0, cmp_count = 0, cycles = 0, i;
  localparam logic [31:0] TBL = 32'h5198_A264;
  // Rows: half_full, direction, expected state index
  localparam logic [4:0]  ROWS [18] = '{5'h19, 5'h1A, 5'h1B, 5'h1C,
    5'h1D, 5'h1E, 5'h1F, 5'h18, 5'h17, 5'h16, 5'h08, 5'h0A, 5'h00,
    5'h06, 5'h1F, 5'h09, 5'h0B, 5'h01};

  // Pin is pulled low when nobody drives it
  assign sync_pin = sync_oe ? sync_out : (ext_on ? ext_lvl : 1'h0);

  stepper_translator_chopper uut (
    .aclk(aclk), .aresetn(aresetn), .ce(ce), .chop_clk(chop_clk),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .host_in(host), .ab_current_sense(ab_sense),
    .cd_current_sense(cd_sense), .sync_in(sync_pin),
    .sync_out(sync_out), .sync_oe(sync_oe), .bridge(bridge),
    .home_sink_on(home_sink_on));

  winding_model far (.chop_clk(chop_clk), .sync_pin(sync_pin),
    .ab_dly(ab_dly), .cd_dly(cd_dly), .ab_sense(ab_sense),
    .cd_sense(cd_sense));

  always #25 aclk = ~aclk;

  initial begin
    chop_clk = 1'h0;
    #7;
    forever #15 chop_clk = ~chop_clk;
  end

  ////////////////////////////////////////////////////////////////////////
  task automatic chk(input string n, input logic [31:0] e, g);
    cmp_count++;
    if (g !== e) begin
      fails++;
      $display("Error %s exp %h got %h", n, e, g);
    end
  endtask

  function automatic drive_t exp_drv(input logic [2:0] x);
    logic [3:0] p;
    p = TBL[4 * (7 - int'(x)) +: 4];
    return {p, |p[3:2], |p[1:0]};
  endfunction

  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d);
    awaddr  <= a;
    wdata   <= d;
    awvalid <= 1'h1;
    wvalid  <= 1'h1;
    bready  <= 1'h1;
    do begin
      @(posedge aclk);
      if (awready) awvalid <= 1'h0;
      if (wready) wvalid <= 1'h0;
    end while (bvalid !== 1'h1);
    rsp = bresp;
    bready <= 1'h0;
    @(posedge aclk);
  endtask

  task automatic axi_rd(input logic [7:0] a);
    araddr  <= a;
    arvalid <= 1'h1;
    rready  <= 1'h1;
    do begin
      @(posedge aclk);
      if (arready) arvalid <= 1'h0;
    end while (rvalid !== 1'h1);
    rd  = rdata;
    rsp = rresp;
    rready <= 1'h0;
    @(posedge aclk);
  endtask

  task automatic step(input logic hf, input logic dir);
    host.step_n             <= 1'h0;
    host.half_full          <= hf;
    host.rotation_direction <= dir;
    repeat (3) @(posedge aclk);
    host.step_n <= 1'h1;
    repeat (6) @(posedge aclk);
  endtask

  // Waits for the next rising edge of the chopper pulse
  task automatic wait_osc();
    int n;
    n = 0;
    do begin
      @(posedge aclk);
      n++;
    end while (sync_out !== 1'h0 && n < 2000);
    do begin
      @(posedge aclk);
      n++;
    end while (sync_out !== 1'h1 && n < 2000);
    if (n >= 2000) fails++;
  endtask

  task automatic finish_test();
    if (fails == 0 && cmp_count > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask

  always @(posedge aclk) begin
    cycles <= cycles + 1;
    if (cycles == 10000) begin
      fails++;
      finish_test();
    end
  end

  ////////////////////////////////////////////////////////////////////////
  initial begin
    aclk = 1'h0;
    aresetn = 1'h0;
    {awvalid, wvalid, bready, arvalid, rready} = 5'h00;
    {awaddr, araddr, wdata} = 48'h0000_0000_0000;
    {ext_on, ext_lvl} = 2'h0;
    {ab_dly, cd_dly} = 20'h0_0000;
    host = 6'h3B;
    ce = 1'h1;
    repeat (8) @(posedge aclk);
    aresetn <= 1'h1;
    @(posedge aclk);
    chk("home_sink_on", 1'h0, home_sink_on);
    axi_rd(CONFIG_OFF);
    chk("config", 32'h0000_0001, rd);
    axi_rd(STATUS_OFF);
    chk("status home", 4'h8, rd[3:0]);
    wait_osc();
    // Pulse is four link cycles, shorter than three bus cycles
    repeat (3) @(posedge aclk);
    chk("sync_out width", 1'h0, sync_out);
    repeat (17) @(posedge aclk);
    chk("bridge home", exp_drv(3'h0), bridge);
    for (i = 0; i < 18; i++) begin
      step(ROWS[i][4], ROWS[i][3]);
      chk("bridge", exp_drv(ROWS[i][2:0]), bridge);
      chk("home_sink_on", ROWS[i][2:0] != 3'h0, home_sink_on);
    end
    host.chip_enable <= 1'h0;
    repeat (8) @(posedge aclk);
    chk("bridge off", 6'h00, bridge);
    host.chip_enable <= 1'h1;
    host.translator_reset_n <= 1'h0;
    step(1'h1, 1'h1);
    host.translator_reset_n <= 1'h1;
    repeat (6) @(posedge aclk);
    chk("bridge reset", exp_drv(3'h0), bridge);
    chk("home_sink_on", 1'h0, home_sink_on);
    ab_dly <= 10'h064;
    wait_osc();
    repeat (200) @(posedge aclk);
    chk("chop inh", {4'h5, 2'h1}, bridge);
    axi_rd(STATUS_OFF);
    chk("latches", 2'h2, rd[5:4]);
    host.chop_target <= 1'h1;
    repeat (8) @(posedge aclk);
    chk("chop phase", {4'hD, 2'h3}, bridge);
    host.chop_target <= 1'h0;
    axi_wr(CONFIG_OFF, 32'h0000_0000);
    chk("config bresp", RESP_OKAY, rsp);
    repeat (700) @(posedge aclk);
    chk("sync_oe", 1'h0, sync_oe);
    chk("no osc", {4'h5, 2'h1}, bridge);
    ext_on  <= 1'h1;
    ext_lvl <= 1'h1;
    repeat (4) @(posedge aclk);
    ext_lvl <= 1'h0;
    repeat (8) @(posedge aclk);
    axi_rd(STATUS_OFF);
    chk("ext latches", 2'h3, rd[5:4]);
    axi_rd(8'h08);
    chk("unmapped rresp", RESP_SLVERR, rsp);
    chk("unmapped rdata", 32'h0000_0000, rd);
    axi_wr(8'h0C, 32'h0000_0001);
    chk("unmapped bresp", RESP_SLVERR, rsp);
    axi_wr(STATUS_OFF, 32'hFFFF_FFFF);
    chk("status bresp", RESP_OKAY, rsp);
    axi_rd(CONFIG_OFF);
    chk("config kept", 32'h0000_0000, rd);
    // Clock enable low: a whole step pulse must be missed
    ce <= 1'h0;
    step(1'h1, 1'h1);
    ce <= 1'h1;
    repeat (6) @(posedge aclk);
    chk("ce hold", 1'h0, home_sink_on);
    // Bus reset in mid-run, away from home
    step(1'h1, 1'h1);
    chk("home_sink_on step", 1'h1, home_sink_on);
    aresetn <= 1'h0;
    repeat (8) @(posedge aclk);
    chk("reset bridge", 6'h00, bridge);
    chk("reset sink", 1'h0, home_sink_on);
    aresetn <= 1'h1;
    @(posedge aclk);
    axi_rd(CONFIG_OFF);
    chk("config after reset", 32'h0000_0001, rd);
    axi_rd(STATUS_OFF);
    chk("status after reset", 4'h8, rd[3:0]);
    finish_test();
  end
endmodule
